// ---- design/sadc_pkg.sv ----
// shared constants and types for the sar converter control block
package sadc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACQ_TIME_NS = 400;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAR_STEP_NS = 400;
  localparam int STEP_CYCLES =
    (SAR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_W = $clog2(STEP_CYCLES);
  localparam int ACQ_W = $clog2(ACQ_CYCLES + 1);
  // serial clock phase inside one step: data moves at 0, decision at last
  localparam int SCLK_RISE = 1;
  localparam int SCLK_FALL = 2;
  // resolution and buffering
  localparam int RES_BITS = 16;
  localparam int BIT_W = $clog2(RES_BITS);
  localparam int FIFO_DEPTH = 8;
  // synchronised pin indices
  localparam int PIN_N = 11;
  localparam int PIN_CNV = 0;
  localparam int PIN_PD = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_CODING = 4;
  localparam int PIN_IFSEL = 5;
  localparam int PIN_BYTE = 6;
  localparam int PIN_CLKSRC = 7;
  localparam int PIN_RDMODE = 8;
  localparam int PIN_SCKINV = 9;
  localparam int PIN_SYNINV = 10;
  // shared data pins carrying the serial port
  localparam int SER_DATA_BIT = 15;
  localparam int SER_CLK_BIT = 14;
  localparam int SER_SYNC_BIT = 13;
  localparam logic [15:0] SER_OE_N = 16'h1FFF;
  localparam logic [15:0] ALL_OFF_N = 16'hFFFF;
  localparam logic [15:0] ALL_ON_N = 16'h0000;

  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_CONV = 2'b01,
    ST_LOAD = 2'b10,
    ST_SEROUT = 2'b11
  } sadc_state_e;

  typedef struct packed {
    logic [PIN_N-1:0] pinMeta;
    logic [PIN_N-1:0] pinSync;
    sadc_state_e st;
    logic cnvPrev;
    logic armed;
    logic [ACQ_W-1:0] acqCnt;
    logic [STEP_W-1:0] stepCnt;
    logic [BIT_W-1:0] bitIdx;
    logic [RES_BITS-1:0] trial;
    logic [RES_BITS-1:0] hold;
    logic [RES_BITS-1:0] shReg;
    logic [RES_BITS-1:0] dout;
    logic [BIT_W:0] shLeft;
    logic shActive;
    logic lowPower;
  } sadc_ctrl_s;
endpackage

// ---- design/sadc_fifo.sv ----
// result fifo with valid and ready on both sides
`timescale 1ns/10ps
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sadc_fifo_s;

  sadc_fifo_s r;
  sadc_fifo_s n;
  logic push;
  logic pop;

  assign inReady = r.cnt != (AW + 1)'(DEPTH);
  assign outValid = r.cnt != '0;
  assign outData = r.mem[r.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = inData;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : AW'(r.wp + 1'b1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : AW'(r.rp + 1'b1);
    end
    if (push && !pop) begin
      n.cnt = (AW + 1)'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      n.cnt = (AW + 1)'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// ---- design/sadc_ctrl.sv ----
// conversion control and data output port of the sar converter
// Notes on behaviour
// - a started conversion always runs to completion
// - convert start ignores chip select and read
// - falling convert start begins conversion, busy high
// - convert start held low free-runs with timed acquisition
// - free-run rate follows internal timing only
// - low power state from conversion end through acquisition
// - output port stays live during acquisition
// - coding select picks binary or two's complement
// - outputs released unless select and read low
// - read low with select low drives result, except serial with clock source select high, where all pins stay released
// - serial port shares the parallel data pins
// - interface select low gives parallel output
// - byte order high swaps the two bytes
// - serial sends sixteen bits, msb first
// - internal clock source makes clock and frame strobe
// - serial clock and frame polarity invertible
// - serial bit stable across both clock edges
// - read mode picks after or during conversion
// - read-after mode keeps busy through sixteen bits
// - serial edges avoid the bit decision instant
// - bits resolved msb first, then code, busy low
`timescale 1ns/10ps
module sadc_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // conversion control pins
  input wire logic convertStartN,
  input wire logic powerDownPin,
  output logic busy,
  output logic lowPower,
  // analog core
  input wire logic compDecision,
  output logic [sadc_pkg::RES_BITS-1:0] dacTrial,
  // configuration pins
  input wire logic codingSelect,
  input wire logic interfaceSelect,
  input wire logic byteOrderSelect,
  input wire logic clockSourceSelect,
  input wire logic readModeOrChainIn,
  input wire logic sclkInvert,
  input wire logic syncInvert,
  // output port
  input wire logic csN,
  input wire logic rdN,
  output logic [sadc_pkg::RES_BITS-1:0] dataOut,
  output logic [sadc_pkg::RES_BITS-1:0] dataOeN
);
  import sadc_pkg::*;

  sadc_ctrl_s r;
  sadc_ctrl_s n;
  logic [PIN_N-1:0] pinsRaw;
  logic cnvLow;
  logic cnvFell;
  logic pdOn;
  logic masterSer;
  logic duringMode;
  logic stepEnd;
  logic sclkLevel;
  logic [RES_BITS-1:0] finalBits;
  logic fifoInValid;
  logic fifoInReady;
  logic [RES_BITS-1:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [RES_BITS-1:0] fifoOutData;

  // output coding: binary keeps the code, two's complement flips the msb
  function automatic logic [RES_BITS-1:0] code_of(
    input logic [RES_BITS-1:0] raw,
    input logic binary
  );
    logic [RES_BITS-1:0] c;
    c = raw;
    if (!binary) begin
      c[RES_BITS-1] = ~raw[RES_BITS-1];
    end
    return c;
  endfunction

  assign pinsRaw[PIN_CNV] = convertStartN;
  assign pinsRaw[PIN_PD] = powerDownPin;
  assign pinsRaw[PIN_CS] = csN;
  assign pinsRaw[PIN_RD] = rdN;
  assign pinsRaw[PIN_CODING] = codingSelect;
  assign pinsRaw[PIN_IFSEL] = interfaceSelect;
  assign pinsRaw[PIN_BYTE] = byteOrderSelect;
  assign pinsRaw[PIN_CLKSRC] = clockSourceSelect;
  assign pinsRaw[PIN_RDMODE] = readModeOrChainIn;
  assign pinsRaw[PIN_SCKINV] = sclkInvert;
  assign pinsRaw[PIN_SYNINV] = syncInvert;

  assign cnvLow = !r.pinSync[PIN_CNV];
  assign cnvFell = r.cnvPrev && cnvLow;
  assign pdOn = r.pinSync[PIN_PD];
  assign masterSer = r.pinSync[PIN_IFSEL] && !r.pinSync[PIN_CLKSRC];
  assign duringMode = masterSer && r.pinSync[PIN_RDMODE];
  assign stepEnd = r.stepCnt == STEP_W'(STEP_CYCLES - 1);

  // last decision folded in before coding
  always_comb begin
    finalBits = r.trial;
    finalBits[0] = compDecision;
  end
  assign fifoInData = code_of(finalBits, r.pinSync[PIN_CODING]);

  sadc_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  always_comb begin
    n = r;
    fifoInValid = 1'b0;
    fifoOutReady = 1'b0;
    n.pinMeta = pinsRaw;
    n.pinSync = r.pinMeta;
    n.cnvPrev = r.pinSync[PIN_CNV];
    if (cnvFell) begin
      n.armed = 1'b1;
    end
    // serial shifter: one bit per step, moved only at step end
    if (r.shActive && stepEnd) begin
      n.shReg = {r.shReg[RES_BITS-2:0], 1'b0};
      n.shLeft = (BIT_W + 1)'(r.shLeft - 1'b1);
      if (r.shLeft == (BIT_W + 1)'(1)) begin
        n.shActive = 1'b0;
      end
    end
    unique case (r.st)
      ST_ACQ: begin
        n.lowPower = 1'b1;
        if (r.acqCnt != '0) begin
          n.acqCnt = ACQ_W'(r.acqCnt - 1'b1);
        end
        if ((r.armed || cnvFell) && cnvLow && !pdOn &&
            (cnvFell || r.acqCnt == '0)) begin
          n.st = ST_CONV;
          n.lowPower = 1'b0;
          n.stepCnt = '0;
          n.bitIdx = BIT_W'(RES_BITS - 1);
          n.trial = '0;
          n.trial[RES_BITS-1] = 1'b1;
          if (duringMode) begin
            n.shReg = r.hold;
            n.shLeft = (BIT_W + 1)'(RES_BITS);
            n.shActive = 1'b1;
          end
        end
      end
      ST_CONV: begin
        // nothing here looks at start, power down or the port
        if (!stepEnd) begin
          n.stepCnt = STEP_W'(r.stepCnt + 1'b1);
        end else begin
          n.trial[r.bitIdx] = compDecision;
          if (r.bitIdx == '0) begin
            fifoInValid = 1'b1;
            if (fifoInReady) begin
              n.st = ST_LOAD;
              n.stepCnt = '0;
            end
          end else begin
            n.trial[r.bitIdx - 1'b1] = 1'b1;
            n.bitIdx = BIT_W'(r.bitIdx - 1'b1);
            n.stepCnt = '0;
          end
        end
      end
      ST_LOAD: begin
        fifoOutReady = !r.shActive;
        if (fifoOutValid && !r.shActive) begin
          n.hold = fifoOutData;
          if (masterSer && !r.pinSync[PIN_RDMODE]) begin
            n.st = ST_SEROUT;
            n.shReg = fifoOutData;
            n.shLeft = (BIT_W + 1)'(RES_BITS);
            n.shActive = 1'b1;
            n.stepCnt = '0;
          end else begin
            n.st = ST_ACQ;
            n.acqCnt = ACQ_W'(ACQ_CYCLES);
            n.lowPower = 1'b1;
          end
        end
      end
      ST_SEROUT: begin
        n.stepCnt = STEP_W'(r.stepCnt + 1'b1);
        if (!r.shActive) begin
          n.st = ST_ACQ;
          n.acqCnt = ACQ_W'(ACQ_CYCLES);
          n.lowPower = 1'b1;
        end
      end
    endcase
    // output data register, live in every state
    sclkLevel = n.shActive &&
      n.stepCnt >= STEP_W'(SCLK_RISE) &&
      n.stepCnt < STEP_W'(SCLK_FALL);
    if (!r.pinSync[PIN_IFSEL]) begin
      n.dout = r.pinSync[PIN_BYTE] ? {r.hold[7:0], r.hold[15:8]} : r.hold;
    end else begin
      n.dout = '0;
      n.dout[SER_DATA_BIT] = n.shActive && n.shReg[RES_BITS-1];
      n.dout[SER_CLK_BIT] = sclkLevel ^ r.pinSync[PIN_SCKINV];
      n.dout[SER_SYNC_BIT] = n.shActive ^ r.pinSync[PIN_SYNINV];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy = r.st != ST_ACQ;
  assign lowPower = r.lowPower;
  assign dacTrial = r.trial;
  assign dataOut = r.dout;

  // pin drivers: enable low drives the pin
  always_comb begin
    if (r.pinSync[PIN_CS] || r.pinSync[PIN_RD]) begin
      dataOeN = ALL_OFF_N;
    end else if (!r.pinSync[PIN_IFSEL]) begin
      dataOeN = ALL_ON_N;
    end else if (!r.pinSync[PIN_CLKSRC]) begin
      dataOeN = SER_OE_N;
    end else begin
      dataOeN = ALL_OFF_N;
    end
  end

  property p_no_abort;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(busy) |-> busy [*8];
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("conversion ended early");

  property p_start_on_fall;
    @(posedge sys_clk) disable iff (!nrst)
    (r.st == ST_ACQ && cnvFell && !pdOn) |=> r.st == ST_CONV && busy;
  endproperty
  a_start_on_fall: assert property (p_start_on_fall)
    else $error("falling start did not begin conversion");

  property p_auto_run;
    @(posedge sys_clk) disable iff (!nrst)
    (r.st == ST_ACQ && r.armed && cnvLow && !pdOn && r.acqCnt == '0)
      |=> r.st == ST_CONV && r.bitIdx == BIT_W'(RES_BITS - 1);
  endproperty
  a_auto_run: assert property (p_auto_run)
    else $error("free-run did not restart");

  property p_low_power;
    @(posedge sys_clk) disable iff (!nrst)
    $fell(busy) |-> lowPower ##1 (lowPower || busy);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power not entered at conversion end");

  property p_release;
    @(posedge sys_clk) disable iff (!nrst)
    (r.pinSync[PIN_CS] || r.pinSync[PIN_RD]) |-> dataOeN == ALL_OFF_N;
  endproperty
  a_release: assert property (p_release)
    else $error("pins driven while deselected");

  property p_byte_swap;
    @(posedge sys_clk) disable iff (!nrst)
    (!r.pinSync[PIN_IFSEL] && r.pinSync[PIN_BYTE])
      |=> dataOut == {$past(r.hold[7:0]), $past(r.hold[15:8])};
  endproperty
  a_byte_swap: assert property (p_byte_swap)
    else $error("byte order wrong");

  property p_msb_order;
    @(posedge sys_clk) disable iff (!nrst)
    (r.st == ST_CONV && stepEnd && r.bitIdx != '0)
      |=> r.bitIdx == BIT_W'($past(r.bitIdx) - 1'b1) && r.stepCnt == '0;
  endproperty
  a_msb_order: assert property (p_msb_order)
    else $error("bit order broken");

  property p_twos;
    @(posedge sys_clk) disable iff (!nrst)
    fifoInValid && !r.pinSync[PIN_CODING]
      |-> fifoInData[RES_BITS-1] == !finalBits[RES_BITS-1] &&
          fifoInData[RES_BITS-2:0] == finalBits[RES_BITS-2:0];
  endproperty
  a_twos: assert property (p_twos)
    else $error("two's complement code wrong");

  property p_busy_serial;
    @(posedge sys_clk) disable iff (!nrst)
    (r.st == ST_SEROUT && r.shActive) |-> busy ##1 busy;
  endproperty
  a_busy_serial: assert property (p_busy_serial)
    else $error("busy fell before serial word done");

  property p_hold_stable;
    @(posedge sys_clk) disable iff (!nrst)
    r.st == ST_CONV |=> $stable(r.hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("held result changed in conversion");

  property p_bit_stable;
    @(posedge sys_clk) disable iff (!nrst)
    (r.shActive && r.stepCnt != STEP_W'(STEP_CYCLES - 1) && n.shActive)
      |=> $stable(r.dout[SER_DATA_BIT]);
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("serial bit moved inside its step");

  c_parallel: cover property (@(posedge sys_clk) disable iff (!nrst)
    $fell(busy) && !r.pinSync[PIN_IFSEL]);
  c_serial_after: cover property (@(posedge sys_clk) disable iff (!nrst)
    r.st == ST_SEROUT ##1 r.st == ST_ACQ);
  c_serial_during: cover property (@(posedge sys_clk) disable iff (!nrst)
    r.st == ST_CONV && r.shActive && duringMode);
  c_free_run: cover property (@(posedge sys_clk) disable iff (!nrst)
    r.st == ST_ACQ && r.acqCnt == '0 && cnvLow && r.armed);
endmodule

// ---- dv/sadc_host_model.sv ----
// host side model: analog comparator and master serial capture
`timescale 1ns/10ps
module sadc_host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // analog core
  input wire logic [15:0] analogIn,
  input wire logic [15:0] dacTrial,
  output logic compDecision,
  // data pins
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOeN,
  input wire logic sclkInvert,
  input wire logic syncInvert,
  // captured serial word
  output logic [15:0] word,
  output logic [4:0] bitCount,
  output logic holdErr
);
  import sadc_pkg::*;
  logic [15:0] pins;
  logic sclk;
  logic frame;
  logic sclkPrev;
  logic framePrev;
  logic bitSeen;
  logic serOn;
  // keep the trial bit while the trial does not exceed the input
  assign compDecision = (dacTrial <= analogIn);
  // released pins read back inverted
  assign pins = dataOut ^ dataOeN;
  assign sclk = pins[SER_CLK_BIT] ^ sclkInvert;
  // only the serial pin pattern counts as a link, not parallel data
  assign serOn = (dataOeN == SER_OE_N);
  assign frame = serOn && (pins[SER_SYNC_BIT] ^ syncInvert);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev <= 1'b0;
      framePrev <= 1'b0;
      bitSeen <= 1'b0;
      word <= 16'h0000;
      bitCount <= 5'h00;
      holdErr <= 1'b0;
    end else begin
      sclkPrev <= sclk;
      framePrev <= frame;
      if (frame && !framePrev) begin
        bitCount <= 5'h00;
      end
      // msb first, one bit per clock rise
      if (frame && sclk && !sclkPrev) begin
        word <= {word[14:0], pins[SER_DATA_BIT]};
        bitSeen <= pins[SER_DATA_BIT];
        bitCount <= bitCount + 5'h01;
      end
      // bit must still hold at the falling edge
      if (frame && !sclk && sclkPrev && pins[SER_DATA_BIT] !== bitSeen) begin
        holdErr <= 1'b1;
      end
    end
  end
endmodule

// ---- dv/sar_adc_conversion_and_output_port_tb_top.sv ----
// testbench for the converter control and output port
`timescale 1ns/10ps
module sar_adc_conversion_and_output_port_tb_top;
  import sadc_pkg::*;
  typedef struct packed {
    logic [15:0] vin;
    logic coding;
    logic swap;
    logic [15:0] exp;
  } sadc_row_s;
  logic sys_clk, nrst, convertStartN, powerDownPin, busy, lowPower;
  logic compDecision, codingSelect, interfaceSelect, byteOrderSelect;
  logic clockSourceSelect, readModeOrChainIn, sclkInvert, syncInvert;
  logic csN, rdN, holdErr;
  logic [15:0] dacTrial, dataOut, dataOeN, analogIn, word;
  logic [4:0] bitCount;
  int errors, totalChecks, busyLen;
  sadc_row_s rows [6] = '{
    '{16'h0000, 1'b1, 1'b0, 16'h0000}, '{16'hFFFF, 1'b1, 1'b0, 16'hFFFF},
    '{16'h8000, 1'b0, 1'b0, 16'h0000}, '{16'h1234, 1'b1, 1'b1, 16'h3412},
    '{16'h00FF, 1'b0, 1'b1, 16'hFF80}, '{16'h7FFF, 1'b0, 1'b0, 16'hFFFF}};

  sadc_ctrl dut (.sys_clk(sys_clk), .nrst(nrst),
    .convertStartN(convertStartN), .powerDownPin(powerDownPin),
    .busy(busy), .lowPower(lowPower), .compDecision(compDecision),
    .dacTrial(dacTrial), .codingSelect(codingSelect),
    .interfaceSelect(interfaceSelect), .byteOrderSelect(byteOrderSelect),
    .clockSourceSelect(clockSourceSelect),
    .readModeOrChainIn(readModeOrChainIn), .sclkInvert(sclkInvert),
    .syncInvert(syncInvert), .csN(csN), .rdN(rdN), .dataOut(dataOut),
    .dataOeN(dataOeN));
  sadc_host_model host (.sys_clk(sys_clk), .nrst(nrst),
    .analogIn(analogIn), .dacTrial(dacTrial), .compDecision(compDecision),
    .dataOut(dataOut), .dataOeN(dataOeN), .sclkInvert(sclkInvert),
    .syncInvert(syncInvert), .word(word), .bitCount(bitCount),
    .holdErr(holdErr));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #10;
    end
  endtask
  task automatic reportAndStop();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic waitBusy(input logic level);
    int n = 0;
    while (busy !== level && n < 400) begin
      tick(1);
      n++;
    end
    if (busy !== level) begin
      errors++;
      $display("unexpected at %0t: busy wait ran out", $time);
      reportAndStop();
    end
  endtask
  // host pulses start, holds it high through acquisition
  task automatic convert();
    convertStartN = 1'b0;
    tick(1);
    waitBusy(1'b1);
    check(dacTrial, 16'h8000, "first trial msb");
    convertStartN = 1'b1;
    check(lowPower, 1'b0, "low power in conversion");
    busyLen = 0;
    while (busy === 1'b1 && busyLen < 400) begin
      tick(1);
      busyLen++;
    end
    waitBusy(1'b0);
    tick(3);
    check(lowPower, 1'b1, "low power in acquisition");
    tick(ACQ_CYCLES);
  endtask

  initial begin
    nrst = 1'b0;
    convertStartN = 1'b0;
    powerDownPin = 1'b0;
    analogIn = 16'h0000;
    codingSelect = 1'b1;
    interfaceSelect = 1'b0;
    byteOrderSelect = 1'b0;
    clockSourceSelect = 1'b0;
    readModeOrChainIn = 1'b0;
    sclkInvert = 1'b0;
    syncInvert = 1'b0;
    csN = 1'b0;
    rdN = 1'b0;
    errors = 0;
    totalChecks = 0;
    tick(16);
    nrst = 1'b1;
    tick(20);
    check(busy, 1'b0, "no start before first fall");
    convertStartN = 1'b1;
    tick(4);
    foreach (rows[i]) begin
      analogIn = rows[i].vin;
      codingSelect = rows[i].coding;
      byteOrderSelect = rows[i].swap;
      tick(3);
      convert();
      check(dataOut, rows[i].exp, "parallel result");
      check(dataOeN, ALL_ON_N, "pins driven");
      check(16'(busyLen <= 70), 16'h0001, "busy width");
    end
    codingSelect = 1'b1;
    byteOrderSelect = 1'b0;
    csN = 1'b1;
    analogIn = 16'h4321;
    tick(3);
    check(dataOeN, ALL_OFF_N, "released, select high");
    convert();
    csN = 1'b0;
    rdN = 1'b1;
    tick(3);
    check(dataOeN, ALL_OFF_N, "released, read high");
    rdN = 1'b0;
    tick(3);
    check(dataOut, 16'h4321, "converted while released");
    analogIn = 16'hABCD;
    convertStartN = 1'b0;
    tick(1);
    waitBusy(1'b1);
    convertStartN = 1'b1;
    tick(4);
    check(dataOut, 16'h4321, "previous result held");
    convertStartN = 1'b0;
    powerDownPin = 1'b1;
    tick(8);
    convertStartN = 1'b1;
    tick(12);
    check(busy, 1'b1, "no abort");
    powerDownPin = 1'b0;
    waitBusy(1'b0);
    tick(ACQ_CYCLES + 8);
    check(busy, 1'b0, "no queued restart");
    check(dataOut, 16'hABCD, "result after abort attempt");
    convertStartN = 1'b0;
    waitBusy(1'b1);
    waitBusy(1'b0);
    tick(ACQ_CYCLES + 3);
    check(busy, 1'b1, "free-run restart");
    convertStartN = 1'b1;
    waitBusy(1'b0);
    tick(ACQ_CYCLES + 4);
    check(busy, 1'b0, "free-run stops");
    interfaceSelect = 1'b1;
    analogIn = 16'h5A5A;
    tick(4);
    convert();
    check(word, 16'h5A5A, "serial word after");
    check({11'h000, bitCount}, 16'h0010, "serial bit count");
    check(dataOeN, SER_OE_N, "serial pins");
    check(16'(busyLen > 128), 16'h0001, "busy through serial");
    readModeOrChainIn = 1'b1;
    sclkInvert = 1'b1;
    syncInvert = 1'b1;
    analogIn = 16'h0F0F;
    tick(4);
    convert();
    check(word, 16'h5A5A, "serial previous word");
    check({11'h000, bitCount}, 16'h0010, "during bit count");
    check(16'(busyLen <= 70), 16'h0001, "busy not extended");
    check(holdErr, 1'b0, "bit stable both edges");
    // free-run burst through the result buffer on the parallel port
    interfaceSelect = 1'b0;
    readModeOrChainIn = 1'b0;
    tick(3);
    for (int i = 0; i < 3; i++) begin
      analogIn = 16'h1111 * 16'(i + 1);
      convertStartN = 1'b0;
      waitBusy(1'b1);
      busyLen = 0;
      while (busy === 1'b1 && busyLen < 400) begin
        tick(1);
        busyLen++;
      end
      check(16'(busyLen), 16'(RES_BITS*STEP_CYCLES+1), "busy");
      tick(2);
      check(lowPower, 1'b1, "burst low power");
      check(dataOut, 16'h1111 * 16'(i + 1), "burst order");
    end
    convertStartN = 1'b1;
    tick(ACQ_CYCLES + 4);
    check(busy, 1'b0, "burst stops");
    reportAndStop();
  end
endmodule
